// ===== core/orc_pkg.sv
package orc_pkg;

	// Bus geometry
	localparam int         ADDR_W   = 18;                  // Byte address width
	localparam int         DATA_W   = 32;                  // Bus data width
	localparam int         REG_W    = 8;                   // Stored register width
	localparam int         N_CFG    = 8;                   // Writable registers

	// Register indices, byte address is four times the index
	localparam logic [15:0] IDX_A_CEIL    = 16'hfe1e;      // Channel A reference ceiling
	localparam logic [15:0] IDX_A_FLOOR   = 16'hfe20;      // Channel A reference floor
	localparam logic [15:0] IDX_B_FLOOR   = 16'hfe21;      // Channel B reference floor
	localparam logic [15:0] IDX_A_HIGH    = 16'hfe22;      // Channel A reference high byte
	localparam logic [15:0] IDX_B_HIGH    = 16'hfe23;      // Channel B reference high byte
	localparam logic [15:0] IDX_A_LOW     = 16'hfe24;      // Channel A reference low nibble
	localparam logic [15:0] IDX_B_LOW     = 16'hfe25;      // Channel B reference low nibble
	localparam logic [15:0] IDX_A_OV      = 16'hfe26;      // Channel A overvoltage setting
	localparam logic [15:0] IDX_A_STATUS  = 16'hfe30;      // Channel A overvoltage status

	// Slot order of the writable registers
	localparam int SLOT_A_CEIL  = 0;
	localparam int SLOT_A_FLOOR = 1;
	localparam int SLOT_B_FLOOR = 2;
	localparam int SLOT_A_HIGH  = 3;
	localparam int SLOT_B_HIGH  = 4;
	localparam int SLOT_A_LOW   = 5;
	localparam int SLOT_B_LOW   = 6;
	localparam int SLOT_A_OV    = 7;

	// Reset values
	localparam logic [7:0] RST_CEIL  = 8'h3f;              // Ceiling opens fully
	localparam logic [7:0] RST_FLOOR = 8'h00;              // Floor fully open
	localparam logic [7:0] RST_HIGH  = 8'h00;              // Reference high byte
	localparam logic [7:0] RST_LOW   = 8'h00;              // Reference low nibble
	localparam logic [7:0] RST_OV    = 8'h00;              // Overvoltage setting

	// Field positions
	localparam int LIMIT_MSB  = 5;                         // Six-bit limit field top
	localparam int NIB_MSB    = 3;                         // Low nibble top
	localparam int DEB_MSB    = 7;                         // Debounce select top
	localparam int DEB_LSB    = 6;                         // Debounce select bottom
	localparam int THR_MSB    = 5;                         // Comparator threshold top
	localparam int STAT_FLAG  = 0;                         // Live debounced flag
	localparam int STAT_LATCH = 1;                         // Sticky flag, write one clears
	localparam int STAT_TRIP  = 2;                         // Synchronised comparator

	// Reference widths
	localparam int REF_W      = 12;                        // Assembled reference width
	localparam int LIMIT_W    = 6;                         // Limit field width

	// Debounce timing
	localparam int CLK_MHZ    = 250;                       // System clock rate
	localparam int DEB_T1_NS  = 960;                       // Select 01, 0.96 us
	localparam int DEB_T2_NS  = 2240;                      // Select 10, 2.24 us
	localparam int DEB_T3_NS  = 8000;                      // Select 11, 8 us
	localparam int DEB_CNT_W  = 11;                        // Counter width
	localparam logic [10:0] DEB_CYC_1 = 11'((DEB_T1_NS * CLK_MHZ) / 1000);
	localparam logic [10:0] DEB_CYC_2 = 11'((DEB_T2_NS * CLK_MHZ) / 1000);
	localparam logic [10:0] DEB_CYC_3 = 11'((DEB_T3_NS * CLK_MHZ) / 1000);

	// Debounce machine states
	typedef enum logic [1:0] {
		ORC_DB_IDLE,
		ORC_DB_COUNT,
		ORC_DB_TRIPPED
	} orc_db_state_t;

endpackage

// ===== core/orc_regs.sv
`timescale 1ns/1ps

module orc_regs #(
	parameter int ADDR_W = orc_pkg::ADDR_W             // Byte address width
) (
	input  wire logic                      sys_clk,            // System clock
	input  wire logic                      rstn,               // Async reset, low
	// APB slave
	input  wire logic                      psel,               // Slave select
	input  wire logic                      penable,            // Access phase
	input  wire logic                      pwrite,             // Write direction
	input  wire logic [ADDR_W-1:0]         paddr,              // Byte address
	input  wire logic [31:0]               pwdata,             // Write data
	input  wire logic [3:0]                pstrb,              // Byte strobes
	output logic                           pready,             // Transfer done
	output logic [31:0]                    prdata,             // Read data
	output logic                           pslverr,            // Unmapped access
	// Loop side
	input  wire logic [11:0]               chanAVoltageSense,  // Channel A ADC
	input  wire logic [11:0]               chanBVoltageSense,  // Channel B ADC
	output logic [11:0]                    chanARefTarget,     // Channel A target
	output logic [11:0]                    chanBRefTarget,     // Channel B target
	output logic signed [12:0]             chanALoopError,     // Target minus sense
	output logic signed [12:0]             chanBLoopError,     // Target minus sense
	// Overvoltage side
	input  wire logic                      chanAOvTripRaw,     // Analog comparator
	output logic [5:0]                     chanAOvThreshold,   // Comparator code
	output logic                           chanAOvFlag         // Debounced flag
);

	// Writable register storage
	logic [7:0]                    cfgReg [orc_pkg::N_CFG];   // Register slots
	logic [7:0]                    statusRead;                // Status byte

	// Index and reset tables in slot order
	localparam logic [15:0] IDX_TABLE [orc_pkg::N_CFG] = '{
		orc_pkg::IDX_A_CEIL, orc_pkg::IDX_A_FLOOR, orc_pkg::IDX_B_FLOOR,
		orc_pkg::IDX_A_HIGH, orc_pkg::IDX_B_HIGH, orc_pkg::IDX_A_LOW,
		orc_pkg::IDX_B_LOW, orc_pkg::IDX_A_OV
	};
	// Ceiling resets fully open, all else resets to zero
	localparam logic [7:0] RST_TABLE [orc_pkg::N_CFG] = '{
		orc_pkg::RST_CEIL, orc_pkg::RST_FLOOR, orc_pkg::RST_FLOOR,
		orc_pkg::RST_HIGH, orc_pkg::RST_HIGH, orc_pkg::RST_LOW,
		orc_pkg::RST_LOW, orc_pkg::RST_OV
	};

	// Word index match, shared by every decode
	// Low two address bits must be zero, so a misaligned access misses
	function automatic logic idxHit(
		input logic [ADDR_W-1:0] addr,
		input logic [15:0]       idx
	);
		logic [ADDR_W-1:0] wordAddr;
		wordAddr = {idx[ADDR_W-3:0], 2'b00};
		idxHit   = (addr == wordAddr);
	endfunction

	// Clamp a reference between floor and ceiling, floor winning
	// A ceiling set below the floor would otherwise invert the window
	function automatic logic [11:0] clampRef(
		input logic [11:0] raw,
		input logic [5:0]  lo,
		input logic [5:0]  hi
	);
		logic [11:0] floorVal;
		logic [11:0] ceilVal;
		floorVal = {lo, 6'h00};
		ceilVal  = {hi, 6'h3f};
		if (raw < floorVal) begin
			clampRef = floorVal;
		end else if (raw > ceilVal) begin
			clampRef = (ceilVal < floorVal) ? floorVal : ceilVal;
		end else begin
			clampRef = raw;
		end
	endfunction

	// ---------------------------------------------------------------
	// Bus decode
	// ---------------------------------------------------------------

	logic [orc_pkg::N_CFG-1:0]    cfgHit;         // One bit per slot
	wire                          statusHit;      // Status register hit
	wire                          anyHit;         // Mapped address
	wire                          setupPhase;     // First cycle of transfer
	wire                          accessPhase;    // Completing cycle
	wire                          writeTake;      // Write lands this edge
	wire                          laneZero;       // Low byte lane enabled

	// Slot hits from the index table
	genvar gi;
	generate
		for (gi = 0; gi < orc_pkg::N_CFG; gi++) begin : g_hit
			assign cfgHit[gi] = idxHit(paddr, IDX_TABLE[gi]);
		end
	endgenerate

	assign statusHit   = idxHit(paddr, orc_pkg::IDX_A_STATUS);
	assign anyHit      = (|cfgHit) | statusHit;
	assign setupPhase  = psel & ~penable;
	assign accessPhase = psel & penable;
	assign laneZero    = pstrb[0];
	// A cleared low lane drops the write without an error
	assign writeTake   = accessPhase & pwrite & anyHit & laneZero;

	// Zero wait state: every access completes in one access cycle
	// A slave that never stalls keeps the master's timing fixed
	assign pready  = 1'b1;
	// Unmapped or misaligned addresses answer with an error
	assign pslverr = accessPhase & ~anyHit;

	// ---------------------------------------------------------------
	// Register storage
	// ---------------------------------------------------------------

	// Each slot takes the low byte on a completing write
	// Reserved bits are stored and read back as written
	generate
		for (gi = 0; gi < orc_pkg::N_CFG; gi++) begin : g_reg
			always_ff @(posedge sys_clk or negedge rstn) begin
				if (!rstn) begin
					cfgReg[gi] <= RST_TABLE[gi];
				end else if (writeTake && cfgHit[gi]) begin
					cfgReg[gi] <= pwdata[7:0];
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// Read path
	// ---------------------------------------------------------------

	logic [7:0]                    readSel;        // Selected byte

	// OR of masked slots, status included
	always_comb begin
		readSel = statusHit ? statusRead : 8'h00;
		for (int i = 0; i < orc_pkg::N_CFG; i++) begin
			readSel = readSel | (cfgHit[i] ? cfgReg[i] : 8'h00);
		end
	end

	// Read data captured in the setup cycle, steady through access
	// Loading in setup keeps the read mux off the access edge
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			prdata <= 32'h0000_0000;
		end else if (setupPhase && !pwrite) begin
			prdata <= {24'h00_0000, readSel};
		end
	end

	// ---------------------------------------------------------------
	// Reference assembly
	// ---------------------------------------------------------------

	wire [11:0]                    chanARefRaw;    // Written A reference
	wire [11:0]                    chanBRefRaw;    // Written B reference
	wire [5:0]                     chanAFloor;     // A floor field
	wire [5:0]                     chanBFloor;     // B floor field
	wire [5:0]                     chanACeil;      // A ceiling field
	wire [11:0]                    chanARefClamp;  // Limited A reference
	wire [11:0]                    chanBRefClamp;  // Limited B reference

	// High byte on top, nibble below
	assign chanARefRaw = {cfgReg[orc_pkg::SLOT_A_HIGH],
		cfgReg[orc_pkg::SLOT_A_LOW][orc_pkg::NIB_MSB:0]};
	assign chanBRefRaw = {cfgReg[orc_pkg::SLOT_B_HIGH],
		cfgReg[orc_pkg::SLOT_B_LOW][orc_pkg::NIB_MSB:0]};

	// Six-bit limit fields
	assign chanAFloor = cfgReg[orc_pkg::SLOT_A_FLOOR][orc_pkg::LIMIT_MSB:0];
	assign chanBFloor = cfgReg[orc_pkg::SLOT_B_FLOOR][orc_pkg::LIMIT_MSB:0];
	assign chanACeil  = cfgReg[orc_pkg::SLOT_A_CEIL][orc_pkg::LIMIT_MSB:0];

	// Channel B has no ceiling here, so its top stays fully open
	assign chanARefClamp = clampRef(chanARefRaw, chanAFloor, chanACeil);
	assign chanBRefClamp = clampRef(chanBRefRaw, chanBFloor, 6'h3f);

	// Registered targets and loop errors
	// A high byte written before its nibble shows for a few cycles
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			chanARefTarget <= 12'h000;
			chanBRefTarget <= 12'h000;
			chanALoopError <= 13'sh0000;
			chanBLoopError <= 13'sh0000;
		end else begin
			chanARefTarget <= chanARefClamp;
			chanBRefTarget <= chanBRefClamp;
			// Positive error asks the loop to raise the output
			chanALoopError <= $signed({1'b0, chanARefClamp})
				- $signed({1'b0, chanAVoltageSense});
			chanBLoopError <= $signed({1'b0, chanBRefClamp})
				- $signed({1'b0, chanBVoltageSense});
		end
	end

	// ---------------------------------------------------------------
	// Overvoltage comparator interface
	// ---------------------------------------------------------------

	logic                          tripMeta;       // First sync stage
	logic                          tripSync;       // Second sync stage
	wire [1:0]                     debSelect;      // Debounce select
	logic [10:0]                   debTarget;      // Cycles to persist

	// Comparator output is asynchronous to the clock
	// Only tripSync feeds logic; tripMeta may still be settling
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			tripMeta <= 1'b0;
			tripSync <= 1'b0;
		end else begin
			tripMeta <= chanAOvTripRaw;
			tripSync <= tripMeta;
		end
	end

	// Threshold code drives the comparator directly
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			chanAOvThreshold <= 6'h00;
		end else begin
			chanAOvThreshold <= cfgReg[orc_pkg::SLOT_A_OV][orc_pkg::THR_MSB:0];
		end
	end

	assign debSelect = cfgReg[orc_pkg::SLOT_A_OV][orc_pkg::DEB_MSB:orc_pkg::DEB_LSB];

	// Select to cycle count
	always_comb begin
		unique case (debSelect)
			2'b00:   debTarget = 11'h000;
			2'b01:   debTarget = orc_pkg::DEB_CYC_1;
			2'b10:   debTarget = orc_pkg::DEB_CYC_2;
			2'b11:   debTarget = orc_pkg::DEB_CYC_3;
		endcase
	end

	// ---------------------------------------------------------------
	// Debounce machine
	// ---------------------------------------------------------------

	orc_pkg::orc_db_state_t        dbState;        // Current state
	orc_pkg::orc_db_state_t        next_dbState;   // Next state
	logic [10:0]                   dbCount;        // Persistence count
	logic [10:0]                   next_dbCount;   // Next count
	logic                          ovLatch;        // Sticky flag copy
	wire                           ovClear;        // Write one to clear
	wire                           ovRise;         // Flag becomes set

	// Count while the trip holds, drop back as soon as it goes
	always_comb begin
		next_dbState = dbState;
		next_dbCount = dbCount;
		unique case (dbState)
			orc_pkg::ORC_DB_IDLE: begin
				if (tripSync) begin
					// Zero time goes straight to the flag
					if (debTarget == 11'h000) begin
						next_dbState = orc_pkg::ORC_DB_TRIPPED;
					end else begin
						next_dbState = orc_pkg::ORC_DB_COUNT;
						next_dbCount = 11'h001;
					end
				end
			end
			orc_pkg::ORC_DB_COUNT: begin
				if (!tripSync) begin
					// Any gap restarts the wait
					next_dbState = orc_pkg::ORC_DB_IDLE;
					next_dbCount = 11'h000;
				end else if (dbCount >= debTarget) begin
					// Count has reached the selected length
					next_dbState = orc_pkg::ORC_DB_TRIPPED;
				end else begin
					next_dbCount = dbCount + 11'h001;
				end
			end
			orc_pkg::ORC_DB_TRIPPED: begin
				// Held while the trip stays, released on the first low
				if (!tripSync) begin
					next_dbState = orc_pkg::ORC_DB_IDLE;
					next_dbCount = 11'h000;
				end
			end
		endcase
	end

	// State and count registers
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			dbState <= orc_pkg::ORC_DB_IDLE;
			dbCount <= 11'h000;
		end else begin
			dbState <= next_dbState;
			dbCount <= next_dbCount;
		end
	end

	// Registered live flag
	// Taken from the next state so flag and state change together
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			chanAOvFlag <= 1'b0;
		end else begin
			chanAOvFlag <= (next_dbState == orc_pkg::ORC_DB_TRIPPED);
		end
	end

	assign ovRise  = (next_dbState == orc_pkg::ORC_DB_TRIPPED)
		& (dbState != orc_pkg::ORC_DB_TRIPPED);
	assign ovClear = writeTake & statusHit & pwdata[orc_pkg::STAT_LATCH];

	// Sticky copy, a new event wins over a clear
	// Keeps a short event visible until software clears it
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ovLatch <= 1'b0;
		end else if (ovRise) begin
			ovLatch <= 1'b1;
		end else if (ovClear) begin
			ovLatch <= 1'b0;
		end
	end

	// Status byte layout
	// Bit 0 live flag, bit 1 sticky, bit 2 synchronised trip
	assign statusRead = {5'h00, tripSync, ovLatch, chanAOvFlag};

endmodule // orc_regs

// ===== tb/orc_regs_assertions.sv
`timescale 1ns/1ps
module orc_regs_assertions #(
	parameter int ADDR_W = orc_pkg::ADDR_W
) (
	input wire logic	sys_clk,
	input wire logic	rstn,
	input wire logic	psel,
	input wire logic	penable,
	input wire logic	pwrite,
	input wire logic [ADDR_W-1:0]	paddr,
	input wire logic [31:0]	pwdata,
	input wire logic [3:0]	pstrb,
	input wire logic	pready,
	input wire logic [31:0]	prdata,
	input wire logic	pslverr,
	input wire logic [11:0]	chanAVoltageSense,
	input wire logic [11:0]	chanBVoltageSense,
	input wire logic [11:0]	chanARefTarget,
	input wire logic [11:0]	chanBRefTarget,
	input wire logic signed [12:0]	chanALoopError,
	input wire logic signed [12:0]	chanBLoopError,
	input wire logic	chanAOvTripRaw,
	input wire logic [5:0]	chanAOvThreshold,
	input wire logic	chanAOvFlag
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	// Access decode
	wire logic [15:0]	accIdx = paddr[ADDR_W-1:2];	// Word index
	wire logic	acc = psel && penable;	// Access phase
	wire logic	accWr = acc && pwrite;	// Write access
	wire logic	mapped = paddr[1:0] == 2'b00 && (accIdx == orc_pkg::IDX_A_STATUS
		|| accIdx == orc_pkg::IDX_A_CEIL
		|| (accIdx >= orc_pkg::IDX_A_FLOOR && accIdx <= orc_pkg::IDX_A_OV));
	wire logic	ovWrite = accWr && pstrb[0] && mapped && accIdx == orc_pkg::IDX_A_OV;
	wire logic [5:0]	thrIn = pwdata[5:0];	// Threshold field of write data
	logic [1:0]	debSel;	// Shadow of debounce select
	logic [11:0]	tripRun;	// Consecutive raw trip cycles
	// Debounce length in cycles: 0, 240, 560, 2000
	wire logic [11:0]	debNeed = (debSel == 2'h0) ? 12'h000 : (debSel == 2'h1) ? 12'h0f0
		: (debSel == 2'h2) ? 12'h230 : 12'h7d0;

	// Shadow select and saturating trip run length
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			debSel <= 2'h0;
			tripRun <= 12'h000;
		end else begin
			if (ovWrite) begin
				debSel <= pwdata[7:6];
			end
			tripRun <= chanAOvTripRaw ? tripRun + {11'h000, ~&tripRun} : 12'h000;
		end
	end

	// Steps of a setting write and a trip release
	sequence s_ov_write;
		ovWrite;
	endsequence
	sequence s_trip_gone;
		!chanAOvTripRaw [*4];
	endsequence

	property p_ready;
		acc |-> pready;
	endproperty
	property p_slverr;
		acc |-> pslverr == !mapped;
	endproperty
	property p_thr;
		s_ov_write |-> ##2 chanAOvThreshold == $past(thrIn, 2);
	endproperty
	property p_ref_cause;
		!$stable(chanARefTarget) || !$stable(chanBRefTarget) |-> $past(accWr, 2);
	endproperty
	property p_err_a;
		$stable(chanAVoltageSense) |=> chanALoopError ==
			$signed({1'b0, chanARefTarget}) - $signed({1'b0, $past(chanAVoltageSense)});
	endproperty
	property p_err_b;
		$stable(chanBVoltageSense) |=> chanBLoopError ==
			$signed({1'b0, chanBRefTarget}) - $signed({1'b0, $past(chanBVoltageSense)});
	endproperty
	property p_flag_early;
		$rose(chanAOvFlag) |-> tripRun >= debNeed + 12'h002;
	endproperty
	property p_flag_late;
		tripRun == debNeed + 12'h008 |-> chanAOvFlag;
	endproperty
	property p_flag_drop;
		s_trip_gone |=> !chanAOvFlag;
	endproperty

	a_ready: assert property (p_ready) else $error("pready low in access");
	a_slverr: assert property (p_slverr) else $error("pslverr wrong for address");
	a_thr: assert property (p_thr) else $error("threshold not copied");
	a_ref_cause: assert property (p_ref_cause) else $error("target moved alone");
	a_err_a: assert property (p_err_a) else $error("channel A loop error wrong");
	a_err_b: assert property (p_err_b) else $error("channel B loop error wrong");
	a_flag_early: assert property (p_flag_early) else $error("flag too early");
	a_flag_late: assert property (p_flag_late) else $error("flag too late");
	a_flag_drop: assert property (p_flag_drop) else $error("flag held");
endmodule // orc_regs_assertions

bind orc_regs orc_regs_assertions #(.ADDR_W(ADDR_W)) orc_regs_assertions_inst (
	.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
	.pslverr(pslverr), .chanAVoltageSense(chanAVoltageSense),
	.chanBVoltageSense(chanBVoltageSense), .chanARefTarget(chanARefTarget),
	.chanBRefTarget(chanBRefTarget), .chanALoopError(chanALoopError),
	.chanBLoopError(chanBLoopError), .chanAOvTripRaw(chanAOvTripRaw),
	.chanAOvThreshold(chanAOvThreshold), .chanAOvFlag(chanAOvFlag));

// ===== tb/testbench.sv
`timescale 1ns/1ps
`define CHK(got, want) begin checksDone++; if ((got) !== (want)) begin fails++; \
	$display("ERROR %0t: got %h expected %h", $time, got, want); end end
module testbench;
	// Stimulus and responses
	logic	sys_clk, rstn, psel, penable, pwrite, pready, pslverr, rdErr;
	logic	chanAOvTripRaw, chanAOvFlag;
	logic [17:0]	paddr;
	logic [31:0]	pwdata, prdata, rdData;
	logic [3:0]	pstrb;
	logic [11:0]	chanAVoltageSense, chanBVoltageSense, chanARefTarget, chanBRefTarget;
	logic signed [12:0]	chanALoopError, chanBLoopError;
	logic [5:0]	chanAOvThreshold;
	int	fails, checksDone, cycles;

	orc_regs #(.ADDR_W(18)) orc_regs_inst (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.chanAVoltageSense(chanAVoltageSense), .chanBVoltageSense(chanBVoltageSense),
		.chanARefTarget(chanARefTarget), .chanBRefTarget(chanBRefTarget),
		.chanALoopError(chanALoopError), .chanBLoopError(chanBLoopError),
		.chanAOvTripRaw(chanAOvTripRaw), .chanAOvThreshold(chanAOvThreshold),
		.chanAOvFlag(chanAOvFlag));

	// Clock, 4 ns period
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// Hang guard
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		if (fails == 0 && checksDone > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// One APB transfer; result lands in rdData and rdErr
	task automatic apb(input logic [15:0] idx, input logic isWr, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= isWr;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		// Wait on pready alone; the hang guard ends a stuck slave
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rdData = prdata;
		rdErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic wr(input logic [15:0] idx, input logic [7:0] d);
		apb(idx, 1'b1, {24'h000000, d});
	endtask

	// Limit defaults after reset
	task automatic t_reset_values();
		apb(orc_pkg::IDX_A_FLOOR, 1'b0, 32'h0);
		`CHK(rdData, 32'h00000000)
		apb(orc_pkg::IDX_B_FLOOR, 1'b0, 32'h0);
		`CHK(rdData, 32'h00000000)
		apb(orc_pkg::IDX_A_CEIL, 1'b0, 32'h0);
		`CHK(rdData, 32'h0000003f)
	endtask

	// Every writable register read back whole, then an unmapped word
	task automatic t_read_write();
		logic [15:0] idx;
		for (int i = 0; i < 8; i++) begin
			idx = (i == 0) ? orc_pkg::IDX_A_CEIL : orc_pkg::IDX_A_FLOOR + 16'(i - 1);
			wr(idx, 8'hc0 | 8'(i * 5));
			apb(idx, 1'b0, 32'h0);
			`CHK(rdData, 32'(8'hc0 | 8'(i * 5)))
		end
		apb(16'hfe27, 1'b1, 32'h000000ff);
		`CHK(rdErr, 1'b1)
		apb(16'hfe27, 1'b0, 32'h0);
		`CHK({rdErr, rdData}, 33'h100000000)
		wr(orc_pkg::IDX_A_FLOOR, 8'h00);
		wr(orc_pkg::IDX_B_FLOOR, 8'h00);
		wr(orc_pkg::IDX_A_CEIL, 8'h3f);
		// Write with the low lane off must not land
		pstrb <= 4'he;
		wr(orc_pkg::IDX_A_FLOOR, 8'h2a);
		pstrb <= 4'hf;
		apb(orc_pkg::IDX_A_FLOOR, 1'b0, 32'h0);
		`CHK(rdData, 32'h00000000)
	endtask

	// High byte plus low nibble, reserved nibble ignored
	task automatic t_reference();
		wr(orc_pkg::IDX_A_HIGH, 8'hab);
		wr(orc_pkg::IDX_A_LOW, 8'hf5);
		wr(orc_pkg::IDX_B_HIGH, 8'h12);
		wr(orc_pkg::IDX_B_LOW, 8'hdc);
		repeat (2) @(posedge sys_clk);
		`CHK(chanARefTarget, 12'hab5)
		`CHK(chanBRefTarget, 12'h12c)
	endtask

	// Floors and ceiling bound the target
	task automatic t_limits();
		wr(orc_pkg::IDX_A_FLOOR, 8'hf0);
		repeat (2) @(posedge sys_clk);
		`CHK(chanARefTarget, 12'hc00)
		wr(orc_pkg::IDX_A_FLOOR, 8'h10);
		wr(orc_pkg::IDX_A_CEIL, 8'h20);
		wr(orc_pkg::IDX_B_FLOOR, 8'h20);
		repeat (2) @(posedge sys_clk);
		`CHK(chanARefTarget, 12'h83f)
		`CHK(chanBRefTarget, 12'h800)
		wr(orc_pkg::IDX_A_FLOOR, 8'h00);
		wr(orc_pkg::IDX_A_CEIL, 8'h3f);
		wr(orc_pkg::IDX_B_FLOOR, 8'h00);
	endtask

	// Error toward the target, both signs
	task automatic t_loop_error();
		chanAVoltageSense <= 12'h0a0;
		chanBVoltageSense <= 12'hfff;
		repeat (3) @(posedge sys_clk);
		`CHK(chanALoopError, 13'h0a15)
		`CHK(chanBLoopError, 13'h112d)
	endtask

	// Every debounce select and threshold ends
	task automatic t_overvoltage();
		int need;
		int n;
		for (int s = 0; s < 4; s++) begin
			// Cycles at 4 ns for 0, 0.96, 2.24 and 8 us
			need = (s == 0) ? 0 : (s == 1) ? 240 : (s == 2) ? 560 : 2000;
			wr(orc_pkg::IDX_A_OV, {2'(s), 6'(s * 21)});
			@(posedge sys_clk);
			`CHK(chanAOvThreshold, 6'(s * 21))
			// Broken trip must not leave credit behind
			if (s > 0) begin
				chanAOvTripRaw <= 1'b1;
				repeat (need / 2 + 1) @(posedge sys_clk);
				chanAOvTripRaw <= 1'b0;
				repeat (4) @(posedge sys_clk);
				`CHK(chanAOvFlag, 1'b0)
			end
			chanAOvTripRaw <= 1'b1;
			n = 0;
			while (chanAOvFlag !== 1'b1 && n < 2100) begin
				@(posedge sys_clk);
				n++;
			end
			`CHK(n >= need + 1 && n <= need + 8, 1'b1)
			// Live flag, sticky copy and trip all set
			apb(orc_pkg::IDX_A_STATUS, 1'b0, 32'h0);
			`CHK(rdData, 32'h00000007)
			chanAOvTripRaw <= 1'b0;
			repeat (5) @(posedge sys_clk);
			`CHK(chanAOvFlag, 1'b0)
			// Sticky copy stays until written one
			apb(orc_pkg::IDX_A_STATUS, 1'b0, 32'h0);
			`CHK(rdData, 32'h00000002)
			wr(orc_pkg::IDX_A_STATUS, 8'h02);
			apb(orc_pkg::IDX_A_STATUS, 1'b0, 32'h0);
			`CHK(rdData, 32'h00000000)
		end
	endtask

	// Main sequence
	initial begin
		rstn <= 1'b0;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 18'h00000;
		pwdata <= 32'h0;
		pstrb <= 4'hf;
		chanAVoltageSense <= 12'h000;
		chanBVoltageSense <= 12'h000;
		chanAOvTripRaw <= 1'b0;
		repeat (16) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		t_reset_values();
		t_read_write();
		t_reference();
		t_limits();
		t_loop_error();
		t_overvoltage();
		give_verdict();
	end
endmodule // testbench
